// >>> common/cpms_pkg.sv
// constants and types shared by the camera power mode supervisor ends
// assumes one 20 MHz clock and a synchronous active-high reset
package cpms_pkg;
  localparam int SW_W   = 8;
  localparam int SEG_W  = 16;
  localparam int PWM_W  = 4;
  localparam int CMD_W  = 4;
  localparam int DATA_W = 16;
  localparam logic [CMD_W-1:0] CMD_CUTOFF  = 4'h1;
  localparam logic [CMD_W-1:0] CMD_SEG     = 4'h2;
  localparam logic [CMD_W-1:0] CMD_BL      = 4'h3;
  localparam logic [CMD_W-1:0] CMD_OV      = 4'h4;
  localparam logic [CMD_W-1:0] CMD_SWREAD  = 4'h5;
  localparam int CLK_HZ         = 20_000_000;
  localparam int RST_DELAY_US   = 100;
  localparam int RST_DELAY_CYC  = RST_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int SUB_DIV        = 610;
  localparam logic [PWM_W-1:0] BL_RESET = 4'h0;
  // apb map for the controller end
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SW     = 8'h08;
  typedef enum logic {CPMS_OFF, CPMS_ON} cpms_mode_t;
endpackage

// >>> common/cpms_if.sv
// link between supervisor and system controller
// assumes both ends share clk
`timescale 1ns/100ps
interface cpms_if;
  import cpms_pkg::*;
  logic              cmd_valid;
  logic [CMD_W-1:0]  cmd_code;
  logic [DATA_W-1:0] cmd_data;
  logic              sw_event;
  logic [SW_W-1:0]   sw_state;
  logic              sw_ack;
  logic              ctrl_powered;
  modport supervisor(input cmd_valid, cmd_code, cmd_data, sw_ack,
                     output sw_event, sw_state, ctrl_powered);
  modport controller(output cmd_valid, cmd_code, cmd_data, sw_ack,
                     input sw_event, sw_state, ctrl_powered);
endinterface

// >>> verilog/cpms_supervisor.sv
// always-powered supervisor: main supply, sleep, switches, display, leds
// assumes inputs synchronous to clk; link commands are one-cycle pulses
`timescale 1ns/100ps
module cpms_supervisor
  import cpms_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  cpms_if.supervisor      link,
  input  wire logic [SW_W-1:0] switches,
  input  wire logic       wake_pin,
  input  wire logic       irq_pin,
  input  wire logic       wake_cause,
  input  wire logic       release_seen,
  output logic            main_camera_supply,
  output logic            metering_processor_rst_n,
  output logic            sub_clock_sel,
  output logic [SEG_W-1:0] segments,
  output logic            backlight_led,
  output logic            overlay_pulse
);
  function automatic logic is_cmd(input logic v, input logic [CMD_W-1:0] c,
                                  input logic [CMD_W-1:0] k);
    return v && (c == k);
  endfunction

  cpms_mode_t          mode;
  logic [SW_W-1:0]     sw_last;
  logic                pending;
  logic [31:0]         rst_cnt;
  logic [PWM_W-1:0]    bl_level;
  logic [PWM_W-1:0]    ov_level;
  logic [PWM_W-1:0]    pwm_cnt;
  logic [9:0]          sub_cnt;
  logic                sw_change;
  logic                wake_req;
  logic                cutoff;

  assign sw_change = (switches != sw_last);
  assign cutoff    = is_cmd(link.cmd_valid, link.cmd_code, CMD_CUTOFF);
  assign wake_req  = wake_pin | irq_pin | wake_cause | sw_change;

  //////////////////////////////////////////////////////////////////////
  // power mode; this logic itself is never gated off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode <= CPMS_ON;
    end else begin
      case (mode)
        CPMS_ON:  if (cutoff && !wake_req) mode <= CPMS_OFF;
        CPMS_OFF: if (wake_req) mode <= CPMS_ON;
        default:  mode <= CPMS_ON;
      endcase
    end
  end
  // one enable feeds controller and image processor blocks
  assign main_camera_supply = (mode == CPMS_ON);
  assign link.ctrl_powered  = (mode == CPMS_ON);
  assign sub_clock_sel      = (mode == CPMS_OFF);

  // metering processor held in reset until the supply settles
  always_ff @(posedge clk) begin
    if (sys_rst || mode == CPMS_OFF) begin
      rst_cnt                  <= '0;
      metering_processor_rst_n <= 1'b0;
    end else if (rst_cnt == 32'(RST_DELAY_CYC - 1)) begin
      metering_processor_rst_n <= 1'b1;
    end else begin
      rst_cnt <= rst_cnt + 32'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // switch capture: a change held pending until the controller acks,
  // and a new change while pending just refreshes the snapshot
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_last <= '0;
      pending <= 1'b0;
    end else begin
      sw_last <= switches;
      if (sw_change)
        pending <= 1'b1;
      else if (link.sw_ack)
        pending <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst)
      link.sw_state <= '0;
    else if (sw_change)
      link.sw_state <= switches;
  end
  assign link.sw_event = pending;

  //////////////////////////////////////////////////////////////////////
  // display and led levels; display kept in both modes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      segments <= '0;
      bl_level <= BL_RESET;
      ov_level <= '0;
    end else begin
      if (is_cmd(link.cmd_valid, link.cmd_code, CMD_SEG))
        segments <= link.cmd_data[SEG_W-1:0];
      if (release_seen)
        bl_level <= '0;
      else if (is_cmd(link.cmd_valid, link.cmd_code, CMD_BL))
        bl_level <= link.cmd_data[PWM_W-1:0];
      if (is_cmd(link.cmd_valid, link.cmd_code, CMD_OV))
        ov_level <= link.cmd_data[PWM_W-1:0];
    end
  end

  // pwm time base; in off mode it steps at sub-clock rate to save power
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sub_cnt <= '0;
      pwm_cnt <= '0;
    end else if (mode == CPMS_ON || sub_cnt == 10'(SUB_DIV - 1)) begin
      sub_cnt <= '0;
      pwm_cnt <= pwm_cnt + 4'h1;
    end else begin
      sub_cnt <= sub_cnt + 10'd1;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      backlight_led <= 1'b0;
      overlay_pulse <= 1'b0;
    end else begin
      backlight_led <= !release_seen && (pwm_cnt < bl_level);
      overlay_pulse <= (pwm_cnt < ov_level);
    end
  end
endmodule

// >>> verilog/cpms_controller.sv
// system controller end: apb registers turned into link commands
// assumes apb master on clk; supervisor answers on the link
`timescale 1ns/100ps
module cpms_controller
  import cpms_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  cpms_if.controller       link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shutdown_ok
);
  logic wr;
  logic rd;
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr == OFS_CMD ||
                   paddr == OFS_STATUS || paddr == OFS_SW);

  //////////////////////////////////////////////////////////////////////
  // cmd word: [19:16] code, [15:0] data; cut-off only when shutdown_ok is high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link.cmd_valid <= 1'b0;
      link.cmd_code  <= '0;
      link.cmd_data  <= '0;
    end else begin
      link.cmd_valid <= wr && paddr == OFS_CMD &&
                        (pwdata[19:16] != CMD_CUTOFF || shutdown_ok);
      if (wr && paddr == OFS_CMD) begin
        link.cmd_code <= pwdata[19:16];
        link.cmd_data <= pwdata[15:0];
      end
    end
  end
  // imaging sensor supply stays with the image processor, not here
  // command pulses never wake that processor; only the wake, irq, cause and switch inputs do
  // reading the switch word acknowledges the pending change
  always_ff @(posedge clk) begin
    if (sys_rst)
      link.sw_ack <= 1'b0;
    else
      link.sw_ack <= rd && paddr == OFS_SW;
  end
  always_ff @(posedge clk) begin
    if (sys_rst)
      prdata <= '0;
    else if (psel && !penable)
      case (paddr)
        OFS_STATUS: prdata <= {30'h0000_0000, link.ctrl_powered,
                               link.sw_event};
        OFS_SW:     prdata <= {24'h00_0000, link.sw_state};
        default:    prdata <= '0;
      endcase
  end
endmodule

// >>> verif/cpms_link_assertions.sv
// link checker: power mode and switch report relations
// assumes one clock domain, instantiated beside the link
`timescale 1ns/100ps
module cpms_link_assertions
  import cpms_pkg::*;
(
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic             cmd_valid,
  input wire logic [CMD_W-1:0] cmd_code,
  input wire logic             sw_event,
  input wire logic [SW_W-1:0]  sw_state,
  input wire logic             sw_ack,
  input wire logic             ctrl_powered
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic cut_q;
  // a supply drop must trace back to a cut-off
  always_ff @(posedge clk) begin
    cut_q <= !sys_rst && cmd_valid && cmd_code == CMD_CUTOFF;
  end
  //////////////////////////////////////////////////////////////
  a_cut_drops: assert property (
    cmd_valid && cmd_code == CMD_CUTOFF |=> !ctrl_powered)
    else $error("supply kept after cut");
  a_drop_cause: assert property (
    $fell(ctrl_powered) |-> cut_q) else $error("drop without cut");
  a_reset_on: assert property (
    $fell(sys_rst) |-> ctrl_powered && !sw_event)
    else $error("bad mode after reset");
  a_event_wakes: assert property (
    $rose(sw_event) |-> ctrl_powered) else $error("no wake on switch");
  a_event_held: assert property (
    sw_event && !sw_ack |=> sw_event) else $error("change lost");
  a_ack_clears: assert property (
    sw_ack ##1 $stable(sw_state) |-> !sw_event)
    else $error("ack not cleared");
  a_change_seen: assert property (
    $changed(sw_state) && !$past(sys_rst) |-> sw_event)
    else $error("change unflagged");
  a_ack_single: assert property (
    sw_ack |=> !sw_ack) else $error("ack too long");
  c_cut: cover property (cmd_valid && cmd_code == CMD_CUTOFF);
  c_wake: cover property ($rose(ctrl_powered));
  c_ack: cover property (sw_event && sw_ack);
endmodule

// >>> verif/camera_power_mode_supervisor_tb.sv
// bench: both link ends joined, driven over apb and side pins
// assumes design files and link checker compiled first
`timescale 1ns/100ps
module camera_power_mode_supervisor_tb;
  import cpms_pkg::*;
  logic        clk, sys_rst, psel, penable, pwrite, ok, er;
  logic        wk, irq, cause, rel, sup, rst_n, sub, bl, ov, rdy, err;
  logic [7:0]  paddr, sw;
  logic [15:0] seg;
  logic [31:0] pwdata, prdata, rd;
  int          errors, samples_checked, h;
  // upper half sent, lower half expected on the segments
  logic [31:0] rows [4] = '{32'h0000_0000, 32'hffff_ffff,
                            32'ha5a5_a5a5, 32'h8001_8001};
  cpms_if link ();
  cpms_supervisor cpms_supervisor_inst (.clk(clk), .sys_rst(sys_rst),
    .link(link), .switches(sw), .wake_pin(wk), .irq_pin(irq),
    .wake_cause(cause), .release_seen(rel), .main_camera_supply(sup),
    .metering_processor_rst_n(rst_n), .sub_clock_sel(sub),
    .segments(seg), .backlight_led(bl), .overlay_pulse(ov));
  cpms_controller cpms_controller_inst (.clk(clk), .sys_rst(sys_rst),
    .link(link), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(rdy),
    .pslverr(err), .shutdown_ok(ok));
  cpms_link_assertions cpms_link_assertions_inst (.clk(clk),
    .sys_rst(sys_rst), .cmd_valid(link.cmd_valid),
    .cmd_code(link.cmd_code), .sw_event(link.sw_event),
    .sw_state(link.sw_state), .sw_ack(link.sw_ack),
    .ctrl_powered(link.ctrl_powered));
  //////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 64);
    rd = prdata;
    er = err;
    {psel, penable} <= 2'h0;
    // a hung slave ends the run here
    if (n >= 64) begin
      chk(0, 1);
      give_verdict();
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [15:0] d);
    apb(1'b1, OFS_CMD, {12'h000, c, d});
    repeat (3) @(negedge clk);
  endtask
  // two full pwm periods, so phase does not matter
  task automatic duty(input logic s);
    h = 0;
    repeat (32) @(negedge clk) h += s ? ov : bl;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sw, wk, irq, cause, rel} = '0;
    {ok, sys_rst, errors, samples_checked} = {2'h3, 64'h0};
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({sup, rst_n, bl, ov, seg}, 20'h8_0000);
    repeat (RST_DELAY_CYC - 10) @(negedge clk);
    chk(rst_n, 0);
    repeat (20) @(negedge clk);
    chk(rst_n, 1);
    foreach (rows[i]) begin
      cmd(CMD_SEG, rows[i][31:16]);
      chk(seg, rows[i][15:0]);
    end
    $display("test reset and segments done");
    cmd(CMD_BL, 16'h0008);
    duty(1'b0);
    chk(h, 16);
    cmd(CMD_OV, 16'h0004);
    duty(1'b1);
    chk(h, 8);
    @(posedge clk);
    rel <= 1'b1;
    repeat (3) @(posedge clk);
    duty(1'b0);
    chk(h, 0);
    @(posedge clk);
    {rel, ok} <= 2'h0;
    cmd(CMD_CUTOFF, 16'h0000);
    chk(sup, 1);
    @(posedge clk);
    ok <= 1'b1;
    cmd(CMD_CUTOFF, 16'h0000);
    chk({sup, sub}, 2'h1);
    cmd(CMD_SEG, 16'h1234);
    chk(seg, 16'h1234);
    $display("test leds and cut-off done");
    for (int i = 0; i < 4; i++) begin
      cmd(CMD_CUTOFF, 16'h0000);
      @(posedge clk);
      {sw[0], cause, irq, wk} <= 4'h1 << i;
      repeat (3) @(negedge clk);
      chk(sup, 1);
      @(posedge clk);
      {cause, irq, wk} <= 3'h0;
    end
    apb(1'b0, OFS_STATUS, 0);
    chk(rd[1:0], 2'h3);
    apb(1'b0, OFS_SW, 0);
    chk(rd[7:0], 8'h01);
    apb(1'b0, OFS_STATUS, 0);
    chk(rd[0], 0);
    apb(1'b0, 8'h0c, 0);
    chk(er, 1);
    $display("test wake and switches done");
    give_verdict();
  end
endmodule
